// >>> pkg/dwdsys_pkg.sv
// dwdsys_pkg: constants shared by the dual watchdog block
package dwdsys_pkg;
  // window watchdog
  localparam int unsigned WIN_CNT_WIDTH   = 7;
  localparam logic [6:0]  WIN_CNT_RESET   = 7'h7F;
  localparam logic [6:0]  WIN_WINDOW_RESET = 7'h7F;
  localparam logic [6:0]  WIN_TIMEOUT_VAL = 7'h3F;
  localparam int unsigned WIN_PRESCALE    = 12288;
  // independent watchdog
  localparam int unsigned IND_CNT_WIDTH   = 8;
  localparam logic [7:0]  IND_RELOAD_RESET = 8'hFF;
  localparam logic [7:0]  IND_KEY_REFRESH = 8'hAA;
  localparam logic [7:0]  IND_KEY_ENABLE  = 8'hCC;
  // option byte bit positions
  localparam int unsigned OPT_IND_HW_BIT  = 2;
  localparam int unsigned OPT_WIN_HW_BIT  = 1;
  localparam int unsigned OPT_OSC_EN_BIT  = 3;
  // low-speed oscillator rate, used to document the tick divider
  localparam int unsigned LSO_FREQ_KHZ    = 128;
  localparam int unsigned CLK_FREQ_KHZ    = 50000;
endpackage : dwdsys_pkg

// >>> pkg/dwdsys_tick_if.sv
// dwdsys_tick_if: tick and reload signals between top and the timer core
`timescale 1ns/1ps
interface dwdsys_tick_if;
  logic       tick;
  logic       reload;
  logic       enable;
  logic       expired;
  modport ctrl (output tick, output reload, output enable, input expired);
  modport core (input tick, input reload, input enable, output expired);
endinterface : dwdsys_tick_if

// >>> test/dwdsys_chk.sv
// dwdsys_chk: port-level assertions for the dual watchdog top
`timescale 1ns/1ps
module dwdsys_chk
  import dwdsys_pkg::*;
#(
  parameter int unsigned WIN_DIV = WIN_PRESCALE
)
(
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       win_ctrl_wr_in,
  input wire logic       win_ctrl_en_in,
  input wire logic       win_window_wr_in,
  input wire logic [6:0] win_window_in,
  input wire logic       ind_key_wr_in,
  input wire logic [7:0] ind_key_in,
  input wire logic       win_active_out,
  input wire logic       ind_active_out,
  input wire logic [6:0] win_count_out,
  input wire logic       opt_error_out,
  input wire logic       reset_req_out
);
  // expiry waits up to one prescaled tick, then two register stages
  localparam int T_MAX = WIN_DIV + 3;
  logic [6:0] thr;
  logic [6:0] next_thr;
  logic       refresh;
  logic       in_win;
  always_comb next_thr = win_window_wr_in ? win_window_in : thr;
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) thr <= WIN_WINDOW_RESET;
    else thr <= next_thr;
  assign refresh = win_active_out && win_ctrl_wr_in && win_ctrl_en_in;
  assign in_win = (win_count_out < thr) && (win_count_out > WIN_TIMEOUT_VAL);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  //////////////////////////////////////////////////////////////////////////////
  property p_win_hold; win_active_out |=> win_active_out; endproperty
  a_win_hold: assert property (p_win_hold) else $error("window enable dropped");
  property p_ind_hold; ind_active_out |=> ind_active_out; endproperty
  a_ind_hold: assert property (p_ind_hold) else $error("indep enable dropped");
  property p_win_en; win_ctrl_wr_in && win_ctrl_en_in |=> win_active_out; endproperty
  a_win_en: assert property (p_win_en) else $error("window not enabled");
  property p_key_en; ind_key_wr_in && ind_key_in == IND_KEY_ENABLE |=> ind_active_out; endproperty
  a_key_en: assert property (p_key_en) else $error("indep not enabled");
  property p_pulse; reset_req_out |=> !reset_req_out; endproperty
  a_pulse: assert property (p_pulse) else $error("request longer than a cycle");
  property p_idle; !win_active_out && !ind_active_out |=> !reset_req_out; endproperty
  a_idle: assert property (p_idle) else $error("request while idle");
  property p_bad; refresh && !in_win |-> ##[1:2] reset_req_out; endproperty
  a_bad: assert property (p_bad) else $error("bad refresh not punished");
  property p_good; refresh && in_win && !ind_active_out |=> !reset_req_out [*2]; endproperty
  a_good: assert property (p_good) else $error("good refresh punished");
  property p_tmo;
    win_active_out && $changed(win_count_out) && win_count_out == WIN_TIMEOUT_VAL
      |-> ##[1:T_MAX] (reset_req_out || win_ctrl_wr_in);
  endproperty
  a_tmo: assert property (p_tmo) else $error("window time-out missed");
  // the enables follow the captured options one cycle later
  property p_opt; opt_error_out |=> win_active_out && ind_active_out; endproperty
  a_opt: assert property (p_opt) else $error("option error left a timer off");
  c_req: cover property (reset_req_out);
  c_bad: cover property (refresh && !in_win);
  c_opt: cover property (opt_error_out);
endmodule : dwdsys_chk
bind dwdsys_top dwdsys_chk #(.WIN_DIV(WIN_DIV)) dwdsys_chk_inst (.clk_in, .arst_n_in,
  .win_ctrl_wr_in, .win_ctrl_en_in, .win_window_wr_in, .win_window_in, .ind_key_wr_in,
  .ind_key_in, .win_active_out, .ind_active_out, .win_count_out, .opt_error_out,
  .reset_req_out);

// >>> test/dwdsys_top_tb.sv
// dwdsys_top_tb: self-checking bench for the dual watchdog top
`timescale 1ns/1ps
module dwdsys_top_tb;
  import dwdsys_pkg::*;
  typedef struct packed {logic [7:0] thr; logic [6:0] at; logic bad;} dwdsys_row_type;
  localparam dwdsys_row_type ROWS [5] = '{'{8'h50, 7'h60, 1'b1}, '{8'h50, 7'h4F, 1'b0},
    '{8'h50, 7'h50, 1'b1}, '{8'h7F, 7'h40, 1'b0}, '{8'h7F, 7'h7E, 1'b0}};
  logic       clk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       low_speed_internal_osc_in = 1'b0;
  logic [7:0] opt_true_in = 8'h00;
  logic [7:0] opt_compl_in = 8'hFF;
  logic       win_ctrl_wr_in = 1'b0;
  logic       win_ctrl_en_in = 1'b0;
  logic [6:0] win_ctrl_cnt_in = 7'h00;
  logic       win_window_wr_in = 1'b0;
  logic [6:0] win_window_in = 7'h00;
  logic       ind_key_wr_in = 1'b0;
  logic [7:0] ind_key_in = 8'h00;
  // short reload keeps the independent expiry near 3500 cycles
  logic [7:0] ind_reload_in = 8'h08;
  logic       win_active_out;
  logic       ind_active_out;
  logic [6:0] win_count_out;
  logic       opt_error_out;
  logic       reset_req_out;
  logic       f;
  int         n;
  int         err_count = 0;
  int         compares = 0;
  dwdsys_top #(.WIN_DIV(4)) dwdsys_top_inst (.clk_in, .arst_n_in, .low_speed_internal_osc_in,
    .opt_true_in, .opt_compl_in, .win_ctrl_wr_in, .win_ctrl_en_in, .win_ctrl_cnt_in,
    .win_window_wr_in, .win_window_in, .ind_key_wr_in, .ind_key_in, .ind_reload_in,
    .win_active_out, .ind_active_out, .win_count_out, .opt_error_out, .reset_req_out);
  always #10 clk_in = ~clk_in;
  always #3906 low_speed_internal_osc_in = ~low_speed_internal_osc_in;
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [2:0] got, input logic [2:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rst(input logic [7:0] t, input logic [7:0] c);
    @(negedge clk_in);
    arst_n_in = 1'b0;
    opt_true_in = t;
    opt_compl_in = c;
    repeat (20) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : rst
  // sel: 0 window refresh, 1 window threshold, 2 key, 3 window write with enable clear
  task wr(input int sel, input logic [7:0] v);
    @(negedge clk_in);
    win_ctrl_wr_in = (sel == 0) || (sel == 3);
    win_ctrl_en_in = (sel == 0);
    win_window_wr_in = (sel == 1);
    ind_key_wr_in = (sel == 2);
    win_ctrl_cnt_in = v[6:0];
    win_window_in = v[6:0];
    ind_key_in = v;
    @(negedge clk_in);
    {win_ctrl_wr_in, win_window_wr_in, ind_key_wr_in} = 3'h0;
  endtask : wr
  task wreq(input int cyc, output logic hit);
    // a pulse launched by the write just taken is already showing
    hit = (reset_req_out === 1'b1);
    repeat (cyc) @(negedge clk_in) if (reset_req_out === 1'b1) hit = 1'b1;
  endtask : wreq
  task finish_test;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    err_count++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(negedge clk_in);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h0);
    $display("reset test done");
    foreach (ROWS[i])
    begin
      rst(8'h00, 8'hFF);
      wr(0, 8'h7F);
      wr(1, ROWS[i].thr);
      n = 0;
      while (win_count_out !== ROWS[i].at && n < 400)
      begin
        @(negedge clk_in);
        n++;
      end
      chk(3'(n < 400), 3'h1);
      wr(0, 8'h7F);
      wreq(3, f);
      chk(3'(f), 3'(ROWS[i].bad));
      $display("window row %0d done", i);
    end
    rst(8'h00, 8'hFF);
    wr(0, 8'h7F);
    wr(3, 8'h7F);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h2);
    wreq(2, f);
    chk(3'(f), 3'h1);
    wreq(400, f);
    chk(3'(f), 3'h1);
    $display("window time-out test done");
    rst(8'h00, 8'hFF);
    wr(2, IND_KEY_REFRESH);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h0);
    wr(2, IND_KEY_ENABLE);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h1);
    repeat (4)
    begin
      wr(2, IND_KEY_REFRESH);
      wreq(1500, f);
      chk(3'(f), 3'h0);
    end
    wreq(6000, f);
    chk(3'(f), 3'h1);
    $display("independent test done");
    rst(8'h04, 8'hFB);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h1);
    // nine oscillator ticks cannot elapse within the first 3000 cycles
    wreq(3000, f);
    chk(3'(f), 3'h0);
    wreq(3000, f);
    chk(3'(f), 3'h1);
    rst(8'h02, 8'hFD);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h2);
    rst(8'h00, 8'h00);
    chk({opt_error_out, win_active_out, ind_active_out}, 3'h7);
    $display("option test done");
    finish_test;
  end
endmodule : dwdsys_top_tb

// >>> verilog/dwdsys_downcnt.sv
// dwdsys_downcnt: loadable down counter that flags end of count
`timescale 1ns/1ps
module dwdsys_downcnt
  import dwdsys_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] load_val,
  output logic      [WIDTH-1:0] count,
  dwdsys_tick_if.core           port
);
  if (WIDTH < 2)
  begin : g_bad_width
    $error("dwdsys_downcnt: WIDTH too small");
  end

  logic [WIDTH-1:0] next_count;
  logic             next_expired;
  logic             expired_q;

  always_comb
  begin
    next_count   = count;
    next_expired = 1'b0;
    if (!port.enable)
      next_count = load_val;
    else if (port.reload)
      next_count = load_val;
    else if (port.tick)
    begin
      if (count == '0)
        next_expired = 1'b1;
      else
        next_count = count - WIDTH'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count     <= '1;
      expired_q <= 1'b0;
    end
    else
    begin
      count     <= next_count;
      expired_q <= next_expired;
    end
  end

  assign port.expired = expired_q;
endmodule : dwdsys_downcnt

// >>> verilog/dwdsys_top.sv
// dwdsys_top: window watchdog plus independent watchdog, reset request output
// Function
// - two independent timers: window and independent
// - enable by software write or option
// - once enabled, only reset disables
// - window watchdog resets on time-out
// - refresh outside window causes reset
// - independent counter ticks from low-speed oscillator
// - hardware option starts independent watchdog at power-on
// - independent watchdog resets unless key written
// - options held true plus complemented copy
`timescale 1ns/1ps
module dwdsys_top
  import dwdsys_pkg::*;
#(
  parameter int unsigned WIN_DIV = WIN_PRESCALE
)
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // low-speed internal oscillator, asynchronous to clk_in
  input  wire logic       low_speed_internal_osc_in,
  // option byte pair
  input  wire logic [7:0] opt_true_in,
  input  wire logic [7:0] opt_compl_in,
  // window watchdog software port
  input  wire logic       win_ctrl_wr_in,
  input  wire logic       win_ctrl_en_in,
  input  wire logic [6:0] win_ctrl_cnt_in,
  input  wire logic       win_window_wr_in,
  input  wire logic [6:0] win_window_in,
  // independent watchdog software port
  input  wire logic       ind_key_wr_in,
  input  wire logic [7:0] ind_key_in,
  input  wire logic [7:0] ind_reload_in,
  // status and reset request
  output logic            win_active_out,
  output logic            ind_active_out,
  output logic [6:0]      win_count_out,
  output logic            opt_error_out,
  output logic            reset_req_out
);
  // the prescaler is 14 bits wide, so larger dividers cannot be served
  if (WIN_DIV < 2 || WIN_DIV > 16384)
  begin : g_bad_div
    $error("dwdsys_top: WIN_DIV out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset release and oscillator synchroniser
  logic [1:0] rst_sync;
  logic       rst_n;
  logic [2:0] osc_sync;

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // osc_sync[0] feeds only osc_sync[1]; edge detect uses stages 1 and 2
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      osc_sync <= 3'h0;
    else
      osc_sync <= {osc_sync[1:0], low_speed_internal_osc_in};
  end

  ////////////////////////////////////////////////////////////////////////////
  // option bytes, captured once after reset release
  logic       opt_loaded;
  logic       opt_ind_hw;
  logic       opt_win_hw;
  logic       opt_bad;
  logic       next_opt_loaded;
  logic       next_opt_ind_hw;
  logic       next_opt_win_hw;
  logic       next_opt_bad;

  always_comb
  begin
    next_opt_loaded = 1'b1;
    next_opt_ind_hw = opt_ind_hw;
    next_opt_win_hw = opt_win_hw;
    next_opt_bad    = opt_bad;
    if (!opt_loaded)
    begin
      // a mismatched pair falls back to the safe side: both watchdogs on
      next_opt_bad    = (opt_true_in != ~opt_compl_in);
      next_opt_ind_hw = opt_true_in[OPT_IND_HW_BIT] | next_opt_bad;
      next_opt_win_hw = opt_true_in[OPT_WIN_HW_BIT] | next_opt_bad;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt_loaded <= 1'b0;
      opt_ind_hw <= 1'b0;
      opt_win_hw <= 1'b0;
      opt_bad    <= 1'b0;
    end
    else
    begin
      opt_loaded <= next_opt_loaded;
      opt_ind_hw <= next_opt_ind_hw;
      opt_win_hw <= next_opt_win_hw;
      opt_bad    <= next_opt_bad;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window watchdog: enable, window register, prescaler
  dwdsys_tick_if win_if ();
  dwdsys_tick_if ind_if ();

  logic        win_en;
  logic [6:0]  win_window;
  logic [6:0]  win_load;
  logic [13:0] win_pre;
  logic        next_win_en;
  logic [6:0]  next_win_window;
  logic [6:0]  next_win_load;
  logic [13:0] next_win_pre;
  logic        win_refresh;
  logic        win_bad_refresh;
  logic [6:0]  win_count;

  // refresh allowed only inside the window and above time-out
  assign win_refresh = win_ctrl_wr_in && win_en
                       && (win_count < win_window)
                       && (win_count > WIN_TIMEOUT_VAL);
  assign win_bad_refresh = win_ctrl_wr_in && win_en && !win_refresh;

  always_comb
  begin
    next_win_en     = win_en;
    next_win_window = win_window;
    next_win_load   = win_load;
    next_win_pre    = win_pre;
    // a clear of the enable bit is ignored once set
    if ((win_ctrl_wr_in && win_ctrl_en_in) || (opt_loaded && opt_win_hw))
      next_win_en = 1'b1;
    if (win_ctrl_wr_in && (!win_en || win_refresh))
      next_win_load = win_ctrl_cnt_in;
    if (win_window_wr_in)
      next_win_window = win_window_in;
    if (!win_en || win_refresh || win_pre == 14'(WIN_DIV - 1))
      next_win_pre = 14'h0;
    else
      next_win_pre = win_pre + 14'h1;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_en     <= 1'b0;
      win_window <= WIN_WINDOW_RESET;
      win_load   <= WIN_CNT_RESET;
      win_pre    <= 14'h0;
    end
    else
    begin
      win_en     <= next_win_en;
      win_window <= next_win_window;
      win_load   <= next_win_load;
      win_pre    <= next_win_pre;
    end
  end

  assign win_if.enable = win_en;
  assign win_if.reload = win_refresh;
  assign win_if.tick   = win_en && (win_pre == 14'(WIN_DIV - 1));

  // counter runs down to the time-out value; offset so core expiry matches
  logic [6:0] win_core_cnt;
  logic [6:0] win_core_load;
  // the enabling write loads its own value, not the one held before it
  assign win_core_load = ((win_refresh || (win_ctrl_wr_in && !win_en)) ? win_ctrl_cnt_in
                          : win_load) - WIN_TIMEOUT_VAL;
  assign win_count     = win_core_cnt + WIN_TIMEOUT_VAL;

  dwdsys_downcnt #(
    .WIDTH    (WIN_CNT_WIDTH)
  ) u_win_cnt (
    .clk      (clk_in),
    .rst_n    (rst_n),
    .load_val (win_core_load),
    .count    (win_core_cnt),
    .port     (win_if.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // independent watchdog: key handling on oscillator ticks
  logic       ind_en;
  logic       next_ind_en;
  logic       ind_refresh_pend;
  logic       next_ind_refresh_pend;
  logic       osc_tick;

  assign osc_tick = osc_sync[1] && !osc_sync[2];

  always_comb
  begin
    next_ind_en           = ind_en;
    next_ind_refresh_pend = ind_refresh_pend;
    if ((ind_key_wr_in && ind_key_in == IND_KEY_ENABLE) || (opt_loaded && opt_ind_hw))
      next_ind_en = 1'b1;
    // a key write in the tick cycle is held, so it is not lost
    if (ind_key_wr_in && ind_key_in == IND_KEY_REFRESH)
      next_ind_refresh_pend = 1'b1;
    else if (osc_tick)
      next_ind_refresh_pend = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ind_en           <= 1'b0;
      ind_refresh_pend <= 1'b0;
    end
    else
    begin
      ind_en           <= next_ind_en;
      ind_refresh_pend <= next_ind_refresh_pend;
    end
  end

  assign ind_if.enable = ind_en;
  assign ind_if.reload = osc_tick && ind_refresh_pend;
  assign ind_if.tick   = osc_tick;

  dwdsys_downcnt #(
    .WIDTH    (IND_CNT_WIDTH)
  ) u_ind_cnt (
    .clk      (clk_in),
    .rst_n    (rst_n),
    .load_val (ind_reload_in),
    .count    (),
    .port     (ind_if.core)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  logic next_reset_req;
  logic reset_req;
  always_comb
  begin
    next_reset_req = win_if.expired || win_bad_refresh || ind_if.expired;
  end

  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      reset_req <= 1'b0;
    else
      reset_req <= next_reset_req;
  end

  assign reset_req_out  = reset_req;
  assign win_active_out = win_en;
  assign ind_active_out = ind_en;
  assign win_count_out  = win_count;
  assign opt_error_out  = opt_bad;
endmodule : dwdsys_top
